// [acu_unit.v]
`include "acu_defs.vh"
module acu_unit (
	// Clock and reset.
	input wire core_clk,
	input wire rstn,
	// Incoming frame bytes.
	input wire rx_valid,
	input wire [7:0] rx_byte,
	// Persistence setting.
	input wire coord_persist,
	// Accumulator preload.
	input wire accu_load,
	input wire [31:0] accu_load_val,
	// Reply.
	output reg reply_valid,
	output reg [7:0] reply_status,
	output reg [7:0] reply_instr,
	output reg [31:0] reply_value,
	// Coordinate store.
	output reg coord_we,
	output reg coord_nv_we,
	output reg [7:0] coord_slot,
	output reg [7:0] coord_motor,
	output reg [31:0] coord_data,
	// Axis parameter table.
	output reg axis_we,
	output reg [7:0] axis_param,
	output reg [7:0] axis_motor,
	output reg [31:0] axis_data,
	// Global parameter table.
	output reg glob_we,
	output reg [7:0] glob_param,
	output reg [7:0] glob_bank,
	output reg [31:0] glob_data,
	// Register state.
	output reg [31:0] accu_r,
	output reg [31:0] xreg_r
);
	localparam ST_RECV = 2'b01;
	localparam ST_EXEC = 2'b10;

	reg [1:0] state_r;
	reg [3:0] idx_r;
	reg [7:0] sum_r;
	reg [7:0] addr_r;
	reg [7:0] ins_r;
	reg [7:0] typ_r;
	reg [7:0] mb_r;
	reg [31:0] val_r;
	reg sum_ok_r;
	wire [31:0] calc_accu;
	wire [31:0] calc_xreg;
	wire calc_bad;

	// True when a frame is addressed to this module.
	function addr_hit;
		input [7:0] a;
		begin
			addr_hit = (a == `ACU_MODULE_ADDR);
		end
	endfunction

	acu_calc u_calc (
		.op(typ_r),
		.accu(accu_r),
		.xreg(xreg_r),
		.accu_out(calc_accu),
		.xreg_out(calc_xreg),
		.bad_op(calc_bad)
	);

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_RECV;
			idx_r <= 4'd0;
			sum_r <= 8'h00;
			addr_r <= 8'h00;
			ins_r <= 8'h00;
			typ_r <= 8'h00;
			mb_r <= 8'h00;
			val_r <= 32'h0000_0000;
			sum_ok_r <= 1'b0;
			reply_valid <= 1'b0;
			reply_status <= 8'h00;
			reply_instr <= 8'h00;
			reply_value <= 32'h0000_0000;
			coord_we <= 1'b0;
			coord_nv_we <= 1'b0;
			coord_slot <= 8'h00;
			coord_motor <= 8'h00;
			coord_data <= 32'h0000_0000;
			axis_we <= 1'b0;
			axis_param <= 8'h00;
			axis_motor <= 8'h00;
			axis_data <= 32'h0000_0000;
			glob_we <= 1'b0;
			glob_param <= 8'h00;
			glob_bank <= 8'h00;
			glob_data <= 32'h0000_0000;
			accu_r <= `ACU_ACCU_RST;
			xreg_r <= `ACU_XREG_RST;
		end else begin
			reply_valid <= 1'b0;
			coord_we <= 1'b0;
			coord_nv_we <= 1'b0;
			axis_we <= 1'b0;
			glob_we <= 1'b0;
			case (state_r)
				ST_RECV: begin
					if (accu_load) begin
						accu_r <= accu_load_val;
					end
					if (rx_valid) begin
						// Bytes arrive address, instruction, type, bank, value MSB first, checksum.
						case (idx_r)
							4'd0: addr_r <= rx_byte;
							4'd1: ins_r <= rx_byte;
							4'd2: typ_r <= rx_byte;
							4'd3: mb_r <= rx_byte;
							`ACU_IDX_SUM: begin
								// The checksum byte is kept out of the value field.
							end
							default: val_r <= {val_r[23:0], rx_byte};
						endcase
						if (idx_r == `ACU_IDX_SUM) begin
							sum_ok_r <= (rx_byte == sum_r);
							idx_r <= 4'd0;
							sum_r <= 8'h00;
							state_r <= ST_EXEC;
						end else begin
							sum_r <= sum_r + rx_byte;
							idx_r <= idx_r + 4'd1;
						end
					end
				end
				ST_EXEC: begin
					state_r <= ST_RECV;
					reply_valid <= addr_hit(addr_r);
					reply_instr <= ins_r;
					reply_value <= 32'h0000_0000;
					reply_status <= `ACU_ST_OK;
					if (!addr_hit(addr_r)) begin
						reply_status <= `ACU_ST_OK;
					end else if (!sum_ok_r) begin
						reply_status <= `ACU_ST_BAD_SUM;
					end else begin
						case (ins_r)
							`ACU_INS_TO_COORD: begin
								coord_we <= 1'b1;
								coord_nv_we <= coord_persist && (typ_r != 8'h00);
								coord_slot <= typ_r;
								coord_motor <= mb_r;
								coord_data <= accu_r;
							end
							`ACU_INS_CALC_WITH_AUX_REGISTER: begin
								if (calc_bad) begin
									reply_status <= `ACU_ST_BAD_TYPE;
								end else begin
									accu_r <= calc_accu;
									xreg_r <= calc_xreg;
								end
							end
							`ACU_INS_TO_AXIS: begin
								axis_we <= 1'b1;
								axis_param <= typ_r;
								axis_motor <= mb_r;
								axis_data <= accu_r;
							end
							`ACU_INS_TO_GLOBAL: begin
								glob_we <= 1'b1;
								glob_param <= typ_r;
								glob_bank <= mb_r;
								glob_data <= accu_r;
							end
							default: reply_status <= `ACU_ST_BAD_CMD;
						endcase
					end
				end
				default: state_r <= ST_RECV;
			endcase
		end
	end
endmodule // acu_unit

// [acu_defs.vh]
`ifndef ACU_DEFS_VH
`define ACU_DEFS_VH
// Instruction codes.
`define ACU_INS_TO_COORD 8'h27
`define ACU_INS_CALC_WITH_AUX_REGISTER 8'h21
`define ACU_INS_TO_AXIS 8'h22
`define ACU_INS_TO_GLOBAL 8'h23
// Operation codes of the auxiliary register calculation.
`define ACU_OP_ADD 8'h00
`define ACU_OP_SUB 8'h01
`define ACU_OP_MUL 8'h02
`define ACU_OP_DIV 8'h03
`define ACU_OP_MOD 8'h04
`define ACU_OP_AND 8'h05
`define ACU_OP_OR 8'h06
`define ACU_OP_XOR 8'h07
`define ACU_OP_NOT 8'h08
`define ACU_OP_LOAD 8'h09
`define ACU_OP_SWAP 8'h0a
// Reply status codes.
`define ACU_ST_OK 8'h64
`define ACU_ST_BAD_SUM 8'h01
`define ACU_ST_BAD_CMD 8'h02
`define ACU_ST_BAD_TYPE 8'h03
// Frame layout.
`define ACU_FRAME_LEN 4'd9
`define ACU_IDX_SUM 4'd8
// Reset values and module address.
`define ACU_ACCU_RST 32'h0000_0000
`define ACU_XREG_RST 32'h0000_0000
`define ACU_MODULE_ADDR 8'h01
`endif

// [acu_calc.v]
`include "acu_defs.vh"
// Combinational calculator for the accumulator and the auxiliary register.
module acu_calc (
	// Operands and operation.
	input wire [7:0] op,
	input wire [31:0] accu,
	input wire [31:0] xreg,
	// Results.
	output reg [31:0] accu_out,
	output reg [31:0] xreg_out,
	output reg bad_op
);
	always @* begin
		accu_out = accu;
		xreg_out = xreg;
		bad_op = 1'b0;
		case (op)
			`ACU_OP_ADD: accu_out = accu + xreg;
			`ACU_OP_SUB: accu_out = accu - xreg;
			`ACU_OP_MUL: accu_out = accu * xreg;
			`ACU_OP_DIV: begin
				if (xreg == 32'h0000_0000) begin
					bad_op = 1'b1;
				end else begin
					accu_out = $signed(accu) / $signed(xreg);
				end
			end
			`ACU_OP_MOD: begin
				if (xreg == 32'h0000_0000) begin
					bad_op = 1'b1;
				end else begin
					accu_out = $signed(accu) % $signed(xreg);
				end
			end
			`ACU_OP_AND: accu_out = accu & xreg;
			`ACU_OP_OR: accu_out = accu | xreg;
			`ACU_OP_XOR: accu_out = accu ^ xreg;
			`ACU_OP_NOT: xreg_out = ~xreg;
			`ACU_OP_LOAD: xreg_out = accu;
			`ACU_OP_SWAP: begin
				accu_out = xreg;
				xreg_out = accu;
			end
			default: bad_op = 1'b1;
		endcase
	end
endmodule // acu_calc

// [acu_host.sv]
module acu_host (
	// Clock.
	input wire logic core_clk,
	// Frame bytes and accumulator preload.
	output logic rx_valid = 1'b0,
	output logic [7:0] rx_byte = 8'h00,
	output logic accu_load = 1'b0,
	output logic [31:0] accu_load_val = 32'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	task send(input logic [7:0] ins, typ, bnk, input logic [31:0] ld, input logic bad);
		logic [71:0] f;
		f = {8'h01, ins, typ, bnk, 32'h0, 8'h00};
		f[7:0] = f[71:64] + ins + typ + bnk + {7'h0, bad};
		for (int i = 8; i >= 0; i--) begin
			@(posedge core_clk) #1;
			rx_valid = 1'b1;
			rx_byte = f[i*8+:8];
			accu_load = (i == 6);
			accu_load_val = ld;
		end
		@(posedge core_clk) #1;
		rx_valid = 1'b0;
		accu_load = 1'b0;
		rx_byte = ~rx_byte;
	endtask
endmodule // acu_host

// [acu_unit_monitor.sv]
module acu_unit_monitor (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Watched ports.
	input wire logic coord_persist,
	input wire logic reply_valid,
	input wire logic [7:0] reply_status,
	input wire logic coord_we,
	input wire logic coord_nv_we,
	input wire logic [7:0] coord_slot,
	input wire logic [31:0] coord_data,
	input wire logic axis_we,
	input wire logic [31:0] axis_data,
	input wire logic glob_we,
	input wire logic [31:0] glob_data,
	input wire logic [31:0] accu_r,
	input wire logic [31:0] xreg_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_nv_slot_zero: assert property (coord_nv_we |-> coord_we && coord_slot != 8'h00)
		else $error("slot zero saved");
	a_nv_follows_set: assert property (coord_we |-> coord_nv_we == ($past(coord_persist) && coord_slot != 8'h00))
		else $error("bad save flag");
	a_coord_from_accu: assert property (coord_we |-> coord_data == accu_r)
		else $error("bad coord data");
	a_axis_from_accu: assert property (axis_we |-> axis_data == accu_r)
		else $error("bad axis data");
	a_glob_from_accu: assert property (glob_we |-> glob_data == accu_r)
		else $error("bad global data");
	a_write_ok: assert property ((coord_we || axis_we || glob_we) |-> reply_valid && reply_status == 8'h64)
		else $error("write without ok");
	a_reply_pulse: assert property (reply_valid |=> !reply_valid)
		else $error("reply too long");
	a_xreg_cause: assert property ($changed(xreg_r) |-> reply_valid && reply_status == 8'h64)
		else $error("x changed alone");
endmodule // acu_unit_monitor

// [tb_top.sv]
`include "acu_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rstn = 0, coord_persist = 0, reply_valid, coord_we, coord_nv_we, axis_we, glob_we, rx_valid, accu_load;
	logic [7:0] reply_status, reply_instr, coord_slot, coord_motor, axis_param, axis_motor, glob_param, glob_bank, rx_byte, st;
	logic [31:0] reply_value, coord_data, axis_data, glob_data, accu_r, xreg_r, accu_load_val;
	logic nv;
	int error_cnt = 0, check_count = 0;
	logic [71:0] rows [11] = '{{8'h00, 32'h16, 32'h5}, {8'h01, 32'hc, 32'h5}, {8'h02, 32'h55, 32'h5},
		{8'h03, 32'h3, 32'h5}, {8'h04, 32'h2, 32'h5}, {8'h05, 32'h1, 32'h5}, {8'h06, 32'h15, 32'h5},
		{8'h07, 32'h14, 32'h5}, {8'h08, 32'h11, 32'hffff_fffa}, {8'h09, 32'h11, 32'h11}, {8'h0a, 32'h5, 32'h11}};
	acu_unit i_dut (.*);
	acu_host i_host (.*);
	always #50 core_clk = ~core_clk;
	task stop_test();
		if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task run(input logic [7:0] ins, typ, bnk, input logic [31:0] ld, input logic bad);
		i_host.send(ins, typ, bnk, ld, bad);
		st = 8'h00;
		for (int i = 0; i < 6 && st === 8'h00; i++) begin
			@(posedge core_clk) #1;
			nv = coord_nv_we;
			if (reply_valid === 1'b1) st = reply_status;
		end
		if (st === 8'h00) begin
			chk(0, "no reply");
			stop_test();
		end else begin
			chk(reply_instr === ins && reply_value === 32'h0, "echo");
		end
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		#1 rstn = 1;
		chk(reply_status === 8'h00 && accu_r === 32'h0 && coord_we === 1'b0, "reset");
		foreach (rows[k]) begin
			run(`ACU_INS_CALC_WITH_AUX_REGISTER, `ACU_OP_LOAD, 8'h00, 32'h5, 0);
			run(`ACU_INS_CALC_WITH_AUX_REGISTER, rows[k][71:64], 8'h00, 32'h11, 0);
			chk(st === 8'h64 && {accu_r, xreg_r} === rows[k][63:0], "calc");
		end
		coord_persist = 1;
		run(`ACU_INS_TO_COORD, 8'h00, 8'h00, 32'h1234, 0);
		chk(st === 8'h64 && !nv && coord_slot === 8'h00 && coord_motor === 8'h00 && coord_data === 32'h1234, "slot0");
		run(`ACU_INS_TO_COORD, 8'h14, 8'h00, 32'h8000_0001, 0);
		chk(nv === 1'b1 && coord_slot === 8'h14 && coord_data === 32'h8000_0001, "save");
		coord_persist = 0;
		run(`ACU_INS_TO_COORD, 8'h01, 8'h00, 32'h7, 0);
		chk(nv === 1'b0 && coord_slot === 8'h01, "ram only");
		run(`ACU_INS_TO_AXIS, 8'h04, 8'h03, 32'hdead_beef, 0);
		chk(st === 8'h64 && axis_param === 8'h04 && axis_motor === 8'h03 && axis_data === 32'hdead_beef, "axis");
		run(`ACU_INS_TO_GLOBAL, 8'h2a, 8'h02, 32'hffff_fff0, 0);
		chk(glob_param === 8'h2a && glob_bank === 8'h02 && glob_data === 32'hffff_fff0, "global");
		run(`ACU_INS_TO_COORD, 8'h03, 8'h00, 32'h77, 1);
		chk(st === 8'h01 && coord_slot === 8'h01, "checksum");
		run(8'h05, 8'h00, 8'h00, 32'h0, 0);
		chk(st === 8'h02, "unknown instruction");
		run(`ACU_INS_CALC_WITH_AUX_REGISTER, 8'h0b, 8'h00, 32'h0, 0);
		chk(st === 8'h03, "bad type");
		run(`ACU_INS_CALC_WITH_AUX_REGISTER, `ACU_OP_LOAD, 8'h00, 32'h0, 0);
		run(`ACU_INS_CALC_WITH_AUX_REGISTER, `ACU_OP_DIV, 8'h00, 32'h9, 0);
		chk(st === 8'h03 && accu_r === 32'h9 && xreg_r === 32'h0, "div by zero");
		stop_test();
	end
endmodule // tb_top
bind acu_unit acu_unit_monitor i_mon (.*);
